// ==== logic/mcr_mode_control.sv ====
`timescale 1ns/1ps
// Summary of operation
// - chop field 11 toggles chop every second elementary conversion, 10 every one.
// - chop field 01 holds chop high, 00 holds it low, and the field resets to 00.
// - pump force-on turns the pump on, wins over force-off, and resets to zero.
// - pump force-off turns the pump off unless force-on is set, and resets to one.
// - reference-output enable drives the reference onto pin 0, reset zero.
// - external-reference enable takes the reference from pin 1, reset zero.
// - pin 1 value drives the pin only when its direction is output and ext ref is off.
// - elementary conversions per conversion equal two to the programmed exponent.
module mcr_mode_control
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        conv_start,
  input  wire logic        elconv_done,
  output logic             chop_state,
  output logic             pump_on,
  output logic             ref_out_pin0_en,
  output logic             ext_ref_pin1_en,
  output logic             pin1_o,
  output logic             pin1_oe,
  output logic             conv_last
);
  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       aw_held;
    logic       w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] mode;
    logic [5:0] ctrl;
    logic [7:0] elcnt;
    logic       pump;
    logic       refo;
    logic       extr;
    logic       p1o;
    logic       p1oe;
    logic       last;
  } mcr_state_s;

  mcr_state_s s_q;
  mcr_state_s s_d;
  logic       chop_w;
  logic       chop_q;

  function automatic logic [1:0] mcr_decode(input logic [7:0] addr);
    if (addr == mcr_pkg::MODE_CONTROL_OFFSET)
    begin
      return 2'h1;
    end
    else if (addr == mcr_pkg::CTRL_OFFSET)
    begin
      return 2'h2;
    end
    else if (addr == mcr_pkg::STATUS_OFFSET)
    begin
      return 2'h3;
    end
    return 2'h0;
  endfunction

  logic [7:0] elconv_total;
  assign elconv_total = 8'h01 << s_q.ctrl[2:0];

  always_comb
  begin
    s_d = s_q;
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    s_d.arready = 1'b0;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_held && !s_q.awready && !s_q.bvalid)
    begin
      s_d.awready = 1'b1;
    end
    if (s_q.awready)
    begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held && !s_q.wready && !s_q.bvalid)
    begin
      s_d.wready = 1'b1;
    end
    if (s_q.wready)
    begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    if (s_q.aw_held && s_q.w_held)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mcr_pkg::RESP_OKAY;
      unique case (mcr_decode(s_q.awaddr))
        2'h1:
        begin
          if (s_q.wstrb0)
          begin
            s_d.mode = s_q.wdata[5:0];
          end
        end
        2'h2:
        begin
          if (s_q.wstrb0)
          begin
            s_d.ctrl = s_q.wdata[5:0];
          end
        end
        2'h3:
        begin
        end
        default: s_d.bresp = mcr_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // read channel
    if (s_axi_arvalid && !s_q.arready && !s_q.rvalid)
    begin
      s_d.arready = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rresp = mcr_pkg::RESP_OKAY;
      s_d.rdata = '0;
      unique case (mcr_decode(s_axi_araddr))
        2'h1: s_d.rdata[7:0] = {mcr_pkg::RSVD_READ, s_q.mode};
        2'h2: s_d.rdata[5:0] = s_q.ctrl;
        2'h3: s_d.rdata[7:0] = {s_q.elcnt};
        default: s_d.rresp = mcr_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    // conversion pacing
    if (conv_start)
    begin
      s_d.elcnt = '0;
      s_d.last = 1'b0;
    end
    else if (elconv_done)
    begin
      s_d.last = (s_q.elcnt + 8'h01) == elconv_total;
      s_d.elcnt = s_d.last ? 8'h00 : s_q.elcnt + 8'h01;
    end
    else
    begin
      s_d.last = 1'b0;
    end
    // pump: force-on wins; with neither forced, default to on
    s_d.pump = s_q.mode[mcr_pkg::PUMP_ON_BIT] | ~s_q.mode[mcr_pkg::PUMP_OFF_BIT];
    s_d.refo = s_q.mode[mcr_pkg::REF_OUT_BIT];
    s_d.extr = s_q.mode[mcr_pkg::EXT_REF_BIT];
    s_d.p1oe = s_q.ctrl[mcr_pkg::CTRL_DIR_BIT] & ~s_q.mode[mcr_pkg::EXT_REF_BIT];
    s_d.p1o = s_q.ctrl[mcr_pkg::CTRL_OUTV_BIT] & s_d.p1oe;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.mode <= mcr_pkg::MODE_CONTROL_RESET[5:0];
      s_q.ctrl <= mcr_pkg::CTRL_RESET;
      chop_q <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
      chop_q <= chop_w;
    end
  end

  mcr_chop_gen u_chop
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .elconv_done (elconv_done),
    .conv_start  (conv_start),
    .chop_mode   (s_q.mode[mcr_pkg::CHOP_MSB:mcr_pkg::CHOP_LSB]),
    .chop_state  (chop_w)
  );

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign chop_state = chop_q;
  assign pump_on = s_q.pump;
  assign ref_out_pin0_en = s_q.refo;
  assign ext_ref_pin1_en = s_q.extr;
  assign pin1_o = s_q.p1o;
  assign pin1_oe = s_q.p1oe;
  assign conv_last = s_q.last;

  a_pump_on_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s_q.mode[3]) |-> pump_on) else $error("force-on did not win");
  a_pump_forced_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s_q.mode[3:2]) == 2'h1 |-> !pump_on) else $error("pump not off");
  a_ref_out_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ref_out_pin0_en == $past(s_q.mode[1])) else $error("ref out wrong");
  a_ext_ref_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ext_ref_pin1_en == $past(s_q.mode[0])) else $error("ext ref wrong");
  a_pin1_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s_q.mode[0]) |-> !pin1_oe && !pin1_o) else $error("pin1 driven with ext ref");
  a_elcnt_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.elcnt < elconv_total) else $error("elementary count overran");
  a_rsvd_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_arready && $past(s_axi_araddr) == mcr_pkg::MODE_CONTROL_OFFSET
    |-> s_axi_rdata[7:6] == 2'h2) else $error("reserved bits misread");
  a_chop_reset_low: assert property (@(posedge aclk)
    !$past(aresetn) |-> !chop_state) else $error("chop not low after reset");
  a_bresp_after_both: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.aw_held && s_q.w_held |=> s_axi_bvalid) else $error("write response missing");

  // bus handshake checks; a ready held high would take a second item
  a_aw_one_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  a_w_one_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_wready |=> !s_axi_wready)
    else $error("write data ready held");
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_with_rvalid: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arready |-> s_axi_rvalid)
    else $error("read taken without data");
  a_aw_blocked_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_ar_blocked_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s_axi_rvalid) && s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_ctrl_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_arready && $past(s_axi_araddr) == mcr_pkg::CTRL_OFFSET
    |-> s_axi_rdata[31:6] == 26'h0) else $error("ctrl upper bits set");
  a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_arready && mcr_decode($past(s_axi_araddr)) == 2'h0
    |-> s_axi_rresp == mcr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");

  // conversion pacing, pin and pump checks
  a_last_needs_done: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_last |-> $past(elconv_done) && !$past(conv_start))
    else $error("end marker without elementary conversion");
  a_elcnt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(conv_start) |-> s_q.elcnt == 8'h00 && !conv_last)
    else $error("count not cleared at start");
  a_pin1_dir_input: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(s_q.ctrl[4]) |-> !pin1_oe)
    else $error("pin1 driven while input");
  a_pin1_value: assert property (@(posedge aclk) disable iff (!aresetn)
    pin1_o |-> pin1_oe)
    else $error("pin1 value without enable");
  a_pump_reset_off: assert property (@(posedge aclk)
    $past(!aresetn) |-> !pump_on)
    else $error("pump on after reset");
  a_pump_free_on: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s_q.mode[3:2]) == 2'h0 |-> pump_on)
    else $error("pump off with no force bit");
  a_refs_reset_off: assert property (@(posedge aclk)
    $past(!aresetn) |-> !ref_out_pin0_en && !ext_ref_pin1_en)
    else $error("reference routing on after reset");
endmodule

// ==== logic/mcr_pkg.sv ====
package mcr_pkg;
  localparam logic [7:0] MODE_CONTROL_OFFSET = 8'h70;
  localparam logic [7:0] MODE_CONTROL_RESET  = 8'h84;
  localparam int CHOP_MSB      = 5;
  localparam int CHOP_LSB      = 4;
  localparam int PUMP_ON_BIT   = 3;
  localparam int PUMP_OFF_BIT  = 2;
  localparam int REF_OUT_BIT   = 1;
  localparam int EXT_REF_BIT   = 0;
  localparam logic [1:0] RSVD_READ = 2'h2;
  localparam logic [1:0] CHOP_LOW  = 2'h0;
  localparam logic [1:0] CHOP_HIGH = 2'h1;
  localparam logic [1:0] CHOP_FULL = 2'h2;
  localparam logic [1:0] CHOP_HALF = 2'h3;
  localparam logic [7:0] CTRL_OFFSET  = 8'h74;
  localparam logic [7:0] STATUS_OFFSET = 8'h78;
  localparam int CTRL_EXP_LSB  = 0;
  localparam int CTRL_DIR_BIT  = 4;
  localparam int CTRL_OUTV_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h21;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== logic/mcr_chop_gen.sv ====
`timescale 1ns/1ps
module mcr_chop_gen
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       elconv_done,
  input  wire logic       conv_start,
  input  wire logic [1:0] chop_mode,
  output logic            chop_state
);
  typedef struct packed {
    logic chop;
    logic half;
  } mcr_chop_s;
  mcr_chop_s s_q;
  mcr_chop_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (conv_start)
    begin
      s_d.half = 1'b0;
    end
    unique case (chop_mode)
      mcr_pkg::CHOP_LOW:  s_d.chop = 1'b0;
      mcr_pkg::CHOP_HIGH: s_d.chop = 1'b1;
      mcr_pkg::CHOP_FULL:
      begin
        if (elconv_done)
        begin
          s_d.chop = ~s_q.chop;
        end
      end
      mcr_pkg::CHOP_HALF:
      begin
        if (elconv_done)
        begin
          s_d.half = ~s_q.half;
          if (s_q.half)
          begin
            s_d.chop = ~s_q.chop;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign chop_state = s_q.chop;

  a_chop_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(chop_mode) == mcr_pkg::CHOP_HIGH && chop_mode == mcr_pkg::CHOP_HIGH
    |-> chop_state) else $error("chop not held high");
  a_chop_full_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    chop_mode == mcr_pkg::CHOP_FULL && elconv_done |=> chop_state != $past(chop_state))
    else $error("chop did not toggle per elementary conversion");
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd;
  logic        awready, wready, bvalid, arready, rvalid, cstart, edone;
  logic [1:0]  bresp, rresp, rsp;
  logic        chop, pump, rout, eref, p1o, p1oe, clast;
  logic [7:0]  mode_m;
  logic [5:0]  ctrl_m;
  logic        chop_m, half_m, seen;
  int          fail_count, samples_checked;

  mcr_mode_control mcr_mode_control_i
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_start(cstart), .elconv_done(edone), .chop_state(chop), .pump_on(pump),
    .ref_out_pin0_en(rout), .ext_ref_pin1_en(eref), .pin1_o(p1o), .pin1_oe(p1oe),
    .conv_last(clast)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask

  task automatic chk_out;
    repeat (3) @(posedge aclk);
    cmp_bit(pump, mode_m[3] | ~mode_m[2]);
    cmp_bit(rout, mode_m[1]);
    cmp_bit(eref, mode_m[0]);
    cmp_bit(p1oe, ctrl_m[4] & ~mode_m[0]);
    cmp_bit(p1o, ctrl_m[5] & ctrl_m[4] & ~mode_m[0]);
  endtask

  task automatic wmode(input logic [7:0] v);
    wr(mcr_pkg::MODE_CONTROL_OFFSET, {24'h0, v});
    cmp_word({30'h0, rsp}, {30'h0, mcr_pkg::RESP_OKAY});
    mode_m = {2'b10, v[5:0]};
    if (!v[5]) chop_m = v[4];
    rd_reg(mcr_pkg::MODE_CONTROL_OFFSET);
    cmp_word(rd, {24'h0, mode_m});
    chk_out;
    if (!v[5]) cmp_bit(chop, chop_m);
  endtask

  // one pulse, then a window long enough to catch the registered end marker
  task automatic pulse(input logic c);
    @(posedge aclk);
    if (c) cstart <= 1'b1;
    else edone <= 1'b1;
    @(posedge aclk);
    cstart <= 1'b0;
    edone <= 1'b0;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge aclk);
      seen = seen | clast;
    end
  endtask

  task automatic conv(input int e);
    pulse(1'b1);
    half_m = 1'b0;
    for (int i = 1; i <= (1 << e); i++)
    begin
      pulse(1'b0);
      if (mode_m[5:4] == 2'h2) chop_m = ~chop_m;
      if (mode_m[5:4] == 2'h3) half_m = ~half_m;
      if (mode_m[5:4] == 2'h3 && !half_m) chop_m = ~chop_m;
      cmp_bit(chop, chop_m);
      cmp_bit(seen, i == (1 << e));
    end
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // whole run is a few thousand cycles; this is ample margin
  initial
  begin
    #500000;
    fail_count++;
    end_of_test;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cstart, edone} = 8'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {fail_count, samples_checked} = 0;
    seed = 32'h3f;
    mode_m = 8'h84;
    ctrl_m = 6'h21;
    {chop_m, half_m} = 2'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(mcr_pkg::MODE_CONTROL_OFFSET);
    cmp_word(rd, 32'h84);
    chk_out;
    $display("test reset done");
    wmode(8'h0c);
    repeat (12)
    begin
      seed = xs(seed);
      wmode(seed[7:0]);
    end
    $display("test random writes done");
    for (int i = 0; i < 8; i++)
    begin
      ctrl_m = {i[1], i[0], 4'h1};
      wr(mcr_pkg::CTRL_OFFSET, {26'h0, ctrl_m});
      rd_reg(mcr_pkg::CTRL_OFFSET);
      cmp_word(rd, {26'h0, ctrl_m});
      wmode({6'h0, i[2], i[2]});
    end
    $display("test pin1 done");
    for (int i = 0; i < 8; i++)
    begin
      ctrl_m[2:0] = i[2:0];
      wr(mcr_pkg::CTRL_OFFSET, {26'h0, ctrl_m});
      wmode({2'h0, i[1:0] ^ 2'h2, 4'h4});
      conv(i);
    end
    $display("test chop done");
    rd_reg(8'h7c);
    cmp_word(rd, 32'h0);
    cmp_word({30'h0, rsp}, {30'h0, mcr_pkg::RESP_SLVERR});
    wr(8'h7c, 32'hff);
    cmp_word({30'h0, rsp}, {30'h0, mcr_pkg::RESP_SLVERR});
    rd_reg(mcr_pkg::MODE_CONTROL_OFFSET);
    cmp_word(rd, {24'h0, mode_m});
    $display("test unmapped done");
    end_of_test;
  end
endmodule
